// [src/scw_pkg.sv]
// Contract
// R1: Low three bits of a loaded word pick its target: 000..100 for the five words.
// R2: Bits 30..27 of the integer/fraction word select the multiplexed test output.
// R3: A 12-bit integer divide value comes from the integer/fraction word.
// R4: Fraction is 13 low bits of low word plus 12 high bits times 2^13.
// R5: Cycle slip reduction is on when its enable bit is 1.
// R6: Host enables cycle slip reduction only with positive phase detector polarity.
// R7: Charge pump current comes from bits 27..24 of the reference divider word.
// R8: Host selects the 8/9 prescaler above 3 GHz.
// R9: Host keeps integer value at least 23 with 4/5, 75 with 8/9.
// R10: Halving bit inserts a toggle stage after the reference counter.
// R11: Doubler off uses falling reference edges; on uses both edges.
// R12: A 5-bit reference counter divides by 1 to 32.
// R13: Modulator resets on each integer/fraction write unless the disable bit is 1.
// R14: Lock after 24 good comparison cycles, or 40 with precision bit set.
// R15: Phase detector polarity follows bit 6 of the function word.
// R16: Bit 5 set enters power-down; cleared restores; registers are kept.
// R17: Power-down loads counters, three-states pump, clears lock; loading continues.
// R18: Bit 4 of the function word three-states the charge pump.
// R19: Bit 3 of the function word holds the counters in reset.
// R20: Bleed field equal to 11 enables negative bleed current.
// R21: Clock divider mode 01 enables switched fastlock.
// R22: A 12-bit fastlock timer comes from bits 18..7 of the test word.
// R23: Serial data enters MSB first, one bit per rising serial clock edge.
// R24: Rising load enable moves the shift register into the selected word.
// R25: Low fraction, reference count, doubler and pump current apply on next integer write.
// R26: Wide bandwidth lasts the programmed number of comparison cycles.
// R27: An out-of-window comparison cycle restarts the lock count and drops lock.
package scw_pkg;
  localparam int WORD_W = 32;
  localparam logic [2:0] SEL_INT_FRACTIONAL_NUMERATOR = 3'h0;
  localparam logic [2:0] SEL_FRACTIONAL_NUMERATOR_LOW = 3'h1;
  localparam logic [2:0] SEL_REF_DIV = 3'h2;
  localparam logic [2:0] SEL_FUNCTION = 3'h3;
  localparam logic [2:0] SEL_TEST = 3'h4;
  localparam int MUX_HI = 30;
  localparam int MUX_LO = 27;
  localparam int INT_HI = 26;
  localparam int INT_LO = 15;
  localparam int FRACTIONAL_NUMERATOR_HI_HI = 14;
  localparam int FRACTIONAL_NUMERATOR_HI_LO = 3;
  localparam int FRACTIONAL_NUMERATOR_LO_HI = 27;
  localparam int FRACTIONAL_NUMERATOR_LO_LO = 15;
  localparam int FRACTIONAL_NUMERATOR_LO_W = 13;
  localparam int CSR_BIT = 28;
  localparam int CPI_HI = 27;
  localparam int CPI_LO = 24;
  localparam int PRESC_BIT = 22;
  localparam int HALF_BIT = 21;
  localparam int DBL_BIT = 20;
  localparam int RDIV_HI = 19;
  localparam int RDIV_LO = 15;
  localparam int MODRST_BIT = 14;
  localparam int LDP_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PD_BIT = 5;
  localparam int CP3_BIT = 4;
  localparam int CRST_BIT = 3;
  localparam int BLEED_HI = 24;
  localparam int BLEED_LO = 23;
  localparam int CLKM_HI = 20;
  localparam int CLKM_LO = 19;
  localparam int TMR_HI = 18;
  localparam int TMR_LO = 7;
  localparam logic [1:0] BLEED_ON = 2'h3;
  localparam logic [1:0] CLKM_FASTLOCK = 2'h1;
  localparam logic [3:0] MUX_FASTLOCK_SW = 4'hC;
  localparam logic [5:0] LOCK_CYC_LO = 6'h18;
  localparam logic [5:0] LOCK_CYC_HI = 6'h28;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  typedef enum logic [0:0] {FL_IDLE, FL_WIDE} scw_fl_state_t;
endpackage

// [src/scw_shift_in.sv]
`timescale 1ns/1ps
`default_nettype none
module scw_shift_in
  import scw_pkg::*;
#(
  parameter int WIDTH = scw_pkg::WORD_W
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_enable,
  output logic [WIDTH-1:0] word_q,
  output logic word_valid_q
);
  logic ser_clk_q;
  logic le_q;
  logic [WIDTH-1:0] shift_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ser_clk_q <= 1'b0;
      le_q <= 1'b0;
      shift_q <= '0;
      word_q <= '0;
      word_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      ser_clk_q <= ser_clk;
      le_q <= load_enable;
      if (ser_clk && !ser_clk_q)
        shift_q <= {shift_q[WIDTH-2:0], ser_data}; // [R23]
      word_valid_q <= load_enable && !le_q; // [R24]
      if (load_enable && !le_q)
        word_q <= shift_q; // [R24]
    end
  end
endmodule // scw_shift_in
`default_nettype wire

// [src/scw_lock_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module scw_lock_detect
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic clear,
  input wire logic cmp_tick,
  input wire logic in_window,
  input wire logic precision,
  output logic locked_q
);
  logic [5:0] count_q;
  logic [5:0] count_d;
  logic [5:0] target;

  assign target = precision ? LOCK_CYC_HI : LOCK_CYC_LO; // [R14]
  assign count_d = (count_q == LOCK_CYC_HI) ? count_q : count_q + 6'h01;

  always_ff @(posedge clk_sys)
  begin
    if (srst || (ce && clear))
    begin
      count_q <= '0;
      locked_q <= 1'b0;
    end
    else if (ce && cmp_tick)
    begin
      if (!in_window)
      begin
        count_q <= '0; // [R27]
        locked_q <= 1'b0; // [R27]
      end
      else
      begin
        count_q <= count_d;
        locked_q <= (count_d >= target); // [R14]
      end
    end
  end
endmodule // scw_lock_detect
`default_nettype wire

// [src/scw_top.sv]
`timescale 1ns/1ps
`default_nettype none
module scw_top
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_enable,
  input wire logic reference_input,
  input wire logic phase_in_window,
  output logic [11:0] int_value_q,
  output logic [24:0] fractional_numerator_q,
  output logic [3:0] test_output_select_q,
  output logic [3:0] pump_current_q,
  output logic prescaler_select_q,
  output logic cycle_slip_reduce_enable_q,
  output logic reference_halving_enable_q,
  output logic doubler_enable_q,
  output logic [4:0] r_divide_q,
  output logic modulator_reset_q,
  output logic lock_detect_precision_q,
  output logic pd_polarity_q,
  output logic power_down_q,
  output logic cp_three_state_q,
  output logic counter_hold_q,
  output logic bleed_enable_q,
  output logic fastlock_enable_q,
  output logic [11:0] fastlock_timer_q,
  output logic pfd_ref_tick_q,
  output logic pfd_ref_level_q,
  output logic lock_detect_q,
  output logic wide_bandwidth_q,
  output logic fastlock_switch_q
);
  import scw_pkg::*;

  function automatic logic word_is(input logic [WORD_W-1:0] w, input logic [2:0] code);
    word_is = (w[2:0] == code);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Serial input and word routing

  logic [WORD_W-1:0] word;
  logic word_valid;
  logic wr_int_fractional_numerator;
  logic wr_fractional_numerator_low;
  logic wr_ref_div;
  logic wr_function;
  logic wr_test;

  scw_shift_in #(
    .WIDTH(WORD_W)
  ) u_shift (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .load_enable(load_enable),
    .word_q(word),
    .word_valid_q(word_valid)
  );

  // Unlisted codes are dropped
  assign wr_int_fractional_numerator = word_valid && word_is(word, SEL_INT_FRACTIONAL_NUMERATOR); // [R1]
  assign wr_fractional_numerator_low = word_valid && word_is(word, SEL_FRACTIONAL_NUMERATOR_LOW); // [R1]
  assign wr_ref_div = word_valid && word_is(word, SEL_REF_DIV); // [R1]
  assign wr_function = word_valid && word_is(word, SEL_FUNCTION); // [R1]
  assign wr_test = word_valid && word_is(word, SEL_TEST); // [R1]

  //////////////////////////////////////////////////////////////////////////////
  // Staged fields waiting for the next integer/fraction write

  logic [FRACTIONAL_NUMERATOR_LO_W-1:0] pend_fractional_numerator_low_q;
  logic [4:0] pend_r_divide_q;
  logic pend_doubler_q;
  logic [3:0] pend_pump_current_q;
  logic modulator_reset_disable_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pend_fractional_numerator_low_q <= '0;
    else if (ce && wr_fractional_numerator_low)
      pend_fractional_numerator_low_q <= word[FRACTIONAL_NUMERATOR_LO_HI:FRACTIONAL_NUMERATOR_LO_LO]; // [R25]
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pend_r_divide_q <= '0;
      pend_doubler_q <= 1'b0;
      pend_pump_current_q <= '0;
    end
    else if (ce && wr_ref_div)
    begin
      pend_r_divide_q <= word[RDIV_HI:RDIV_LO]; // [R25]
      pend_doubler_q <= word[DBL_BIT]; // [R25]
      pend_pump_current_q <= word[CPI_HI:CPI_LO]; // [R25]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Integer/fraction word; it also commits the staged fields

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      int_value_q <= '0;
      fractional_numerator_q <= '0;
      test_output_select_q <= '0;
      r_divide_q <= '0;
      doubler_enable_q <= 1'b0;
      pump_current_q <= '0;
    end
    else if (ce && wr_int_fractional_numerator)
    begin
      test_output_select_q <= word[MUX_HI:MUX_LO]; // [R2]
      int_value_q <= word[INT_HI:INT_LO]; // [R3]
      fractional_numerator_q <= {word[FRACTIONAL_NUMERATOR_HI_HI:FRACTIONAL_NUMERATOR_HI_LO], pend_fractional_numerator_low_q}; // [R4] [R25]
      r_divide_q <= pend_r_divide_q; // [R25] [R12]
      doubler_enable_q <= pend_doubler_q; // [R25] [R11]
      pump_current_q <= pend_pump_current_q; // [R25] [R7]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      modulator_reset_q <= 1'b0;
    else if (ce)
      modulator_reset_q <= wr_int_fractional_numerator && !modulator_reset_disable_q; // [R13]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference divider word, immediate fields

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cycle_slip_reduce_enable_q <= 1'b0;
      prescaler_select_q <= 1'b0;
      reference_halving_enable_q <= 1'b0;
    end
    else if (ce && wr_ref_div)
    begin
      cycle_slip_reduce_enable_q <= word[CSR_BIT]; // [R5]
      prescaler_select_q <= word[PRESC_BIT];
      reference_halving_enable_q <= word[HALF_BIT]; // [R10]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Function word

  logic pump_tristate_bit_q;
  logic counter_reset_bit_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      modulator_reset_disable_q <= 1'b0;
      lock_detect_precision_q <= 1'b0;
      pd_polarity_q <= 1'b0;
      power_down_q <= 1'b0;
      pump_tristate_bit_q <= 1'b0;
      counter_reset_bit_q <= 1'b0;
    end
    else if (ce && wr_function)
    begin
      modulator_reset_disable_q <= word[MODRST_BIT]; // [R13]
      lock_detect_precision_q <= word[LDP_BIT]; // [R14]
      pd_polarity_q <= word[POL_BIT]; // [R15]
      power_down_q <= word[PD_BIT]; // [R16]
      pump_tristate_bit_q <= word[CP3_BIT]; // [R18]
      counter_reset_bit_q <= word[CRST_BIT]; // [R19]
    end
  end

  // Power-down three-states the pump and holds the counters, and clears lock and fastlock state; stored words stay intact
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cp_three_state_q <= 1'b0;
      counter_hold_q <= 1'b0;
    end
    else if (ce)
    begin
      cp_three_state_q <= pump_tristate_bit_q || power_down_q; // [R18] [R17] [R16]
      counter_hold_q <= counter_reset_bit_q || power_down_q; // [R19] [R17]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test word

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bleed_enable_q <= 1'b0;
      fastlock_enable_q <= 1'b0;
      fastlock_timer_q <= '0;
    end
    else if (ce && wr_test)
    begin
      bleed_enable_q <= (word[BLEED_HI:BLEED_LO] == BLEED_ON); // [R20]
      fastlock_enable_q <= (word[CLKM_HI:CLKM_LO] == CLKM_FASTLOCK); // [R21]
      fastlock_timer_q <= word[TMR_HI:TMR_LO]; // [R22]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference path: edge pick, R counter, optional halving stage

  logic ref_q;
  logic ref_edge;
  logic [4:0] r_count_q;
  logic [4:0] r_last;
  logic r_out;
  logic half_q;
  logic cmp_tick;

  assign ref_edge = doubler_enable_q ? (ref_q != reference_input) : (ref_q && !reference_input); // [R11]
  // Field value 0 divides by 32
  assign r_last = r_divide_q - 5'h01; // [R12]
  assign r_out = ref_edge && (r_count_q == r_last);
  assign cmp_tick = reference_halving_enable_q ? (r_out && half_q) : r_out; // [R10]

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ref_q <= 1'b0;
    else if (ce)
      ref_q <= reference_input;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || (ce && counter_hold_q))
    begin
      r_count_q <= '0; // [R17] [R19]
      half_q <= 1'b0;
    end
    else if (ce && ref_edge)
    begin
      r_count_q <= r_out ? 5'h00 : r_count_q + 5'h01; // [R12]
      if (r_out)
        half_q <= !half_q; // [R10]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pfd_ref_tick_q <= 1'b0;
      pfd_ref_level_q <= 1'b0;
    end
    else if (ce)
    begin
      pfd_ref_tick_q <= cmp_tick && !counter_hold_q;
      pfd_ref_level_q <= reference_halving_enable_q ? half_q : r_out; // [R10]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Digital lock detect

  scw_lock_detect u_lock (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .clear(power_down_q), // [R17]
    .cmp_tick(pfd_ref_tick_q),
    .in_window(phase_in_window),
    .precision(lock_detect_precision_q),
    .locked_q(lock_detect_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Switched fastlock timer, started by an integer/fraction write

  scw_fl_state_t fl_state_q;
  logic [11:0] fl_count_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst || (ce && power_down_q))
    begin
      fl_state_q <= FL_IDLE;
      fl_count_q <= '0;
    end
    else if (ce)
    begin
      unique case (fl_state_q)
        FL_IDLE:
        begin
          if (wr_int_fractional_numerator && fastlock_enable_q && (fastlock_timer_q != 12'h000))
          begin
            fl_state_q <= FL_WIDE; // [R21]
            fl_count_q <= fastlock_timer_q; // [R26]
          end
        end
        FL_WIDE:
        begin
          if (!fastlock_enable_q)
            fl_state_q <= FL_IDLE;
          else if (pfd_ref_tick_q)
          begin
            fl_count_q <= fl_count_q - 12'h001; // [R26]
            if (fl_count_q == 12'h001)
              fl_state_q <= FL_IDLE; // [R26]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wide_bandwidth_q <= 1'b0;
      fastlock_switch_q <= 1'b0;
    end
    else if (ce)
    begin
      wide_bandwidth_q <= (fl_state_q == FL_WIDE); // [R26]
      fastlock_switch_q <= (fl_state_q == FL_WIDE) && (test_output_select_q == MUX_FASTLOCK_SW); // [R2]
    end
  end
endmodule // scw_top
`default_nettype wire

// [tb/scw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scw_host_model
(
  input wire logic clk_sys,
  output var logic ser_clk,
  output var logic ser_data,
  output var logic load_enable
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_enable = 1'b0;
  end
  ////////////////////////////////////////
  // One full frame: low then high serial clock for each bit, then a load pulse
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge clk_sys);
      #1 ser_clk = 1'b0;
      ser_data = w[i];
      @(posedge clk_sys);
      #1 ser_clk = 1'b1;
    end
    @(posedge clk_sys);
    #1 ser_clk = 1'b0;
    // Released data line shows the inverse, so a stale bit cannot pass
    ser_data = ~w[0];
    @(posedge clk_sys);
    #1 load_enable = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 load_enable = 1'b0;
  endtask
endmodule // scw_host_model
`default_nettype wire

// [tb/scw_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module scw_top_checker
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic phase_in_window,
  input wire logic [3:0] test_output_select_q,
  input wire logic lock_detect_precision_q,
  input wire logic power_down_q,
  input wire logic cp_three_state_q,
  input wire logic counter_hold_q,
  input wire logic modulator_reset_q,
  input wire logic fastlock_enable_q,
  input wire logic [11:0] fastlock_timer_q,
  input wire logic pfd_ref_tick_q,
  input wire logic pfd_ref_level_q,
  input wire logic reference_halving_enable_q,
  input wire logic lock_detect_q,
  input wire logic wide_bandwidth_q,
  input wire logic fastlock_switch_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [5:0] good_q;
  logic [12:0] wide_q;
  ////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (srst || power_down_q || (pfd_ref_tick_q && !phase_in_window))
      good_q <= 6'h00;
    else if (pfd_ref_tick_q && good_q != 6'h3F)
      good_q <= good_q + 6'h01;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst || !wide_bandwidth_q)
      wide_q <= 13'h0000;
    else if (pfd_ref_tick_q)
      wide_q <= wide_q + 13'h0001;
  end
  ////////////////////////////////////////
  sequence s_pd_held;
    power_down_q ##1 power_down_q;
  endsequence
  a_pd_tristates_pump: assert property (s_pd_held |-> cp_three_state_q)
    else $error("pump not three-stated in power-down");
  a_pd_holds_counters: assert property (s_pd_held |-> counter_hold_q)
    else $error("counters not held in power-down");
  a_pd_clears_lock: assert property (s_pd_held |-> !lock_detect_q)
    else $error("lock kept in power-down");
  a_hold_stops_ticks: assert property (counter_hold_q [*3] |-> !pfd_ref_tick_q)
    else $error("comparison tick while counters held");
  a_lock_after_count: assert property ($rose(lock_detect_q) |->
    good_q >= ($past(lock_detect_precision_q) ? 6'h28 : 6'h18))
    else $error("lock set before enough good cycles");
  a_bad_tick_unlocks: assert property (pfd_ref_tick_q && !phase_in_window |=> !lock_detect_q)
    else $error("lock kept after bad cycle");
  a_mod_reset_pulse: assert property (modulator_reset_q |=> !modulator_reset_q)
    else $error("modulator reset longer than one cycle");
  a_wide_needs_mode: assert property (wide_bandwidth_q |-> fastlock_enable_q || $past(fastlock_enable_q)
    || $past(fastlock_enable_q, 2) || $past(fastlock_enable_q, 3))
    else $error("wide bandwidth without fastlock mode");
  a_wide_time_bound: assert property (wide_q <= {1'b0, fastlock_timer_q} + 13'h0001)
    else $error("wide bandwidth outlasts timer");
  a_switch_needs_select: assert property (fastlock_switch_q |-> test_output_select_q == 4'hC
    || $past(test_output_select_q) == 4'hC)
    else $error("fastlock switch without its selection");
  a_tick_on_level: assert property (pfd_ref_tick_q |-> pfd_ref_level_q)
    else $error("comparison tick without reference level");
  a_half_level_falls: assert property (reference_halving_enable_q && $past(reference_halving_enable_q)
    && pfd_ref_tick_q |=> !pfd_ref_level_q)
    else $error("halved reference level not toggling");
endmodule // scw_top_checker
bind scw_top scw_top_checker u_scw_top_checker (.*);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scw_pkg::*;
  typedef struct {int kind; logic [72:0] v;} scw_note_t;
  logic clk_sys, srst, ce, ser_clk, ser_data, load_enable, reference_input, phase_in_window;
  logic [11:0] int_value_q, fastlock_timer_q;
  logic [24:0] fractional_numerator_q;
  logic [3:0] test_output_select_q, pump_current_q;
  logic [4:0] r_divide_q;
  logic prescaler_select_q, cycle_slip_reduce_enable_q, reference_halving_enable_q, doubler_enable_q;
  logic modulator_reset_q, lock_detect_precision_q, pd_polarity_q, power_down_q, cp_three_state_q;
  logic counter_hold_q, bleed_enable_q, fastlock_enable_q, pfd_ref_tick_q, pfd_ref_level_q;
  logic lock_detect_q, wide_bandwidth_q, fastlock_switch_q, obs, pseen, ref_on;
  logic [31:0] sh [5];
  logic [31:0] a1, a2, x, w;
  scw_note_t q [$];
  scw_note_t n;
  int fails, num_checks;
  scw_top u_scw_top (.*);
  scw_host_model u_scw_host_model (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_enable(load_enable));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [72:0] exp_snap();
    return {sh[0][26:15], sh[0][14:3], a1[27:15], sh[0][30:27], a2[27:24], sh[2][22], sh[2][28],
      sh[2][21], a2[20], a2[19:15], sh[3][7:6], sh[3][5], sh[3][4] | sh[3][5], sh[3][3] | sh[3][5],
      sh[4][24:23] == 2'h3, sh[4][20:19] == 2'h1, sh[4][18:7]};
  endfunction
  function automatic logic [72:0] snap();
    return {int_value_q, fractional_numerator_q, test_output_select_q, pump_current_q,
      prescaler_select_q, cycle_slip_reduce_enable_q, reference_halving_enable_q, doubler_enable_q,
      r_divide_q, lock_detect_precision_q, pd_polarity_q, power_down_q, cp_three_state_q,
      counter_hold_q, bleed_enable_q, fastlock_enable_q, fastlock_timer_q};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_snap(logic [72:0] e, logic [72:0] s);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR field_outputs expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic s);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic note(int k, logic [72:0] v);
    q.push_back('{k, v});
    obs = 1'b1;
    @(posedge clk_sys);
    #1 obs = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [31:0] v);
    u_scw_host_model.send(v);
    if (v[2:0] <= SEL_TEST)
      sh[v[2:0]] = v;
    if (v[2:0] == SEL_INT_FRACTIONAL_NUMERATOR)
    begin
      a1 = sh[1];
      a2 = sh[2];
    end
    note(0, exp_snap());
    note(1, 73'(v[2:0] == SEL_INT_FRACTIONAL_NUMERATOR && !sh[3][14]));
  endtask
  task automatic ticks(int k);
    int t;
    t = 0;
    for (int i = 0; i < 2000 && t < k; i++)
    begin
      @(posedge clk_sys);
      if (pfd_ref_tick_q === 1'b1)
        t++;
    end
    #1;
    if (t < k)
    begin
      fails++;
      $display("ERROR pfd_ref_tick_q expected %0d seen %0d", k, t);
      summarize();
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  forever
  begin
    repeat (3) @(posedge clk_sys);
    #1 if (ref_on) reference_input = ~reference_input;
  end
  always @(posedge clk_sys)
  begin
    if (modulator_reset_q === 1'b1)
      pseen = 1'b1;
    if (obs === 1'b1)
    begin
      n = q.pop_front();
      if (n.kind == 0)
        cmp_snap(n.v, snap());
      else if (n.kind == 1)
        cmp_bit("modulator_reset_q", n.v[0], pseen);
      else if (n.kind == 2)
        cmp_bit("lock_detect_q", n.v[0], lock_detect_q);
      else
      begin
        cmp_bit("wide_bandwidth_q", n.v[0], wide_bandwidth_q);
        cmp_bit("fastlock_switch_q", n.v[0], fastlock_switch_q);
      end
      if (n.kind == 1)
        pseen = 1'b0;
    end
  end
  ////////////////////////////////////////
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    reference_input = 1'b0;
    phase_in_window = 1'b0;
    {obs, pseen, ref_on} = 3'h0;
    x = 32'h0000_4A59;
    {fails, num_checks} = 0;
    {a1, a2} = 64'h0;
    foreach (sh[i]) sh[i] = 32'h0000_0000;
    repeat (16) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int i = 0; i < 4; i++)
      for (int c = 4; c >= 0; c--)
      begin
        w = rnd();
        w[2:0] = 3'(c);
        if (c == 0 && w[26:15] < 12'h04B)
          w[26:15] += 12'h04B;
        if (c == 2)
        begin
          w[CSR_BIT] &= sh[3][POL_BIT];
          w[PRESC_BIT] |= i[0];
        end
        wr(w);
      end
    wr(32'h0000_0004);
    for (int c = 5; c < 8; c++)
    begin
      w = rnd();
      w[2:0] = 3'(c);
      wr(w);
    end
    $display("test random_words done");
    ref_on = 1'b1;
    for (int l = 0; l < 2; l++)
    begin
      wr(32'h0008_0284);
      wr(l ? 32'h0000_00C3 : 32'h0000_0043);
      wr(l ? 32'h0020_8002 : 32'h0000_8002);
      wr(32'h6032_0000);
      note(3, 73'h1);
      phase_in_window = 1'b0;
      ticks(1);
      phase_in_window = 1'b1;
      ticks(l ? 38 : 22);
      note(2, 73'h0);
      ticks(4);
      note(2, 73'h1);
      note(3, 73'h0);
      if (l == 0)
      begin
        phase_in_window = 1'b0;
        ticks(1);
        phase_in_window = 1'b1;
        ticks(1);
      end
      else
        wr(32'h0000_00E3);
      note(2, 73'h0);
      $display("test lock_detect pass %0d done", l);
    end
    wr(32'h0000_0043);
    summarize();
  end
endmodule // testbench
`default_nettype wire
